// file: design/dsl_host.sv
// controlling end: makes the link clock from clk and sends frames
module dsl_host (
  input wire logic clk,
  input wire logic sys_rst,
  dsl_link_if.host bus,
  input wire logic send_valid,
  output logic send_ready,
  input wire logic [dsl_pkg::CODE_W-1:0] code_a,
  input wire logic [dsl_pkg::CODE_W-1:0] code_b,
  output logic frame_done,
  output logic [dsl_pkg::FRAME_W-1:0] chain_data
);
  // link phases of one frame
  typedef enum {
    DSL_IDLE,
    DSL_SELECT,
    DSL_LOW,
    DSL_HIGH,
    DSL_TAIL,
    DSL_LOAD
  } dsl_host_state_t;

  dsl_host_state_t state;
  logic [dsl_pkg::CNT_W-1:0] cnt;      // cycles left in this phase
  logic [dsl_pkg::BIT_W-1:0] bit_idx;  // bits still to send
  logic [dsl_pkg::FRAME_W-1:0] word;   // outgoing frame
  logic [dsl_pkg::FRAME_W-1:0] rx;     // returned cascade bits
  logic sclk_q;
  logic din_q;
  logic sel_q;
  logic dout_s;                        // synchronised cascade input

  // pins come straight from flops
  assign bus.sclk = sclk_q;
  assign bus.din = din_q;
  assign bus.select_load_n = sel_q;

  // cascade return bit brought into this domain
  dsl_sync #(
    .RST_VAL (1'b0)
  ) u_dout_sync (
    .clk (clk),
    .sys_rst (sys_rst),
    .async_in (bus.dout),
    .sync_out (dout_s)
  );

  // frame sequencer and link pins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= DSL_IDLE;
      cnt <= '0;
      bit_idx <= '0;
      word <= dsl_pkg::FRAME_RST;
      rx <= dsl_pkg::FRAME_RST;
      sclk_q <= 1'b0;
      din_q <= 1'b0;
      sel_q <= 1'b1;
      send_ready <= 1'b1;
      frame_done <= 1'b0;
      chain_data <= dsl_pkg::FRAME_RST;
    end else begin
      frame_done <= 1'b0;
      unique case (state)
        DSL_IDLE: begin
          // clock already low before select falls; see R06
          if (send_valid && send_ready) begin
            word <= {code_a, code_b}; // see R02
            sel_q <= 1'b0;
            send_ready <= 1'b0;
            cnt <= dsl_pkg::CNT_W'(dsl_pkg::SEL_CYC - 1);
            state <= DSL_SELECT;
          end
        end
        DSL_SELECT: begin
          // select-to-clock gap, then present the first bit
          if (cnt == '0) begin
            din_q <= word[dsl_pkg::FRAME_W-1]; // see R03
            bit_idx <= dsl_pkg::BIT_W'(dsl_pkg::FRAME_W - 1);
            cnt <= dsl_pkg::CNT_W'(dsl_pkg::LOW_CYC - 1);
            state <= DSL_LOW;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        DSL_LOW: begin
          // low time covers data setup; rise and sample the chain
          if (cnt == '0) begin
            sclk_q <= 1'b1;
            rx <= {rx[dsl_pkg::FRAME_W-2:0], dout_s};
            cnt <= dsl_pkg::CNT_W'(dsl_pkg::HIGH_CYC - 1);
            state <= DSL_HIGH;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        DSL_HIGH: begin
          if (cnt == '0) begin
            sclk_q <= 1'b0;
            if (bit_idx == '0) begin
              cnt <= dsl_pkg::CNT_W'(dsl_pkg::TAIL_CYC - 1);
              state <= DSL_TAIL;
            end else begin
              // next bit changes on the falling edge, MSB first
              word <= {word[dsl_pkg::FRAME_W-2:0], 1'b0};
              din_q <= word[dsl_pkg::FRAME_W-2]; // see R03
              bit_idx <= bit_idx - 1'b1;
              cnt <= dsl_pkg::CNT_W'(dsl_pkg::LOW_CYC - 1);
              state <= DSL_LOW;
            end
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        DSL_TAIL: begin
          // last rise to load gap, then one load for all; see R10
          if (cnt == '0) begin
            sel_q <= 1'b1;
            cnt <= dsl_pkg::CNT_W'(dsl_pkg::LOAD_CYC - 1);
            state <= DSL_LOAD;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        DSL_LOAD: begin
          // select held high long enough for the far end to see it
          if (cnt == '0) begin
            send_ready <= 1'b1;
            frame_done <= 1'b1;
            chain_data <= rx;
            state <= DSL_IDLE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
      endcase
    end
  end
endmodule

// file: design/dsl_pkg.sv
// shared constants for the dual-channel serial load link
package dsl_pkg;
  // widths of one channel code and of one whole frame
  localparam int CODE_W = 12;
  localparam int CHAN_N = 2;
  localparam int FRAME_W = CODE_W * CHAN_N;
  // free-running shift count, wide enough for long cascades
  localparam int BITCNT_W = 8;
  // straight binary end codes of a channel
  localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;
  localparam logic [CODE_W-1:0] CODE_FULL = 12'hFFF;
  localparam logic [CODE_W-1:0] CODE_RST = 12'h000;
  localparam logic [FRAME_W-1:0] FRAME_RST = 24'h000000;
  localparam logic [BITCNT_W-1:0] BITCNT_RST = 8'h00;
  localparam logic [BITCNT_W-1:0] FRAME_BITS = 8'h18;
  // system clock period
  localparam int CLK_PERIOD_NS = 25;
  // link timing minimums, in ns
  localparam int T_SETUP_NS = 40;
  localparam int T_HIGH_NS = 40;
  localparam int T_LOW_NS = 40;
  localparam int T_LOAD_PW_NS = 50;
  localparam int T_LSB_TO_LOAD_NS = 40;
  localparam int T_SEL_TO_CLK_NS = 20;
  // least times rounded up to whole clock cycles
  localparam int HIGH_CYC = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOW_NS_MAX = (T_LOW_NS > T_SETUP_NS) ? T_LOW_NS : T_SETUP_NS;
  localparam int LOW_CYC = (LOW_NS_MAX + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEL_CYC =
    (T_SEL_TO_CLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TAIL_CYC =
    (T_LSB_TO_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_PW_CYC =
    (T_LOAD_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // extra high time so the device side synchroniser sees the load
  localparam int SYNC_MARGIN_CYC = 3;
  localparam int LOAD_CYC = LOAD_PW_CYC + SYNC_MARGIN_CYC;
  localparam int CNT_W = 4;
  localparam int BIT_W = 5;
endpackage

// file: design/dsl_link_if.sv
// three-wire load link plus the cascade output
interface dsl_link_if;
  logic sclk;          // serial clock, made by the host
  logic din;           // serial data into the device
  logic select_load_n; // low enables the clock, rising edge loads
  logic dout;          // last shift stage, for cascading
  // the converter end
  modport dev (
    input sclk,
    input din,
    input select_load_n,
    output dout
  );
  // the controlling end
  modport host (
    output sclk,
    output din,
    output select_load_n,
    input dout
  );
endinterface

// file: design/dsl_sync.sv
// two-flop level synchroniser with a chosen reset level
module dsl_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic async_in,
  output logic sync_out
);
  logic meta; // first stage, read only by the second

  // both stages settle to the idle level under reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// file: design/dsl_device.sv
// How it works
// R01: shift data in on rising enabled clock
// R02: frame is 24 bits, A then B
// R03: host sends each code MSB first
// R04: rising select_load copies both codes at once
// R05: clock blocked while select_load is high
// R06: host keeps clock low before selecting
// R07: serial output is the last stage
// R08: serial output changes on rising clock
// R09: cascade chains output into next input
// R10: cascade loads all devices with one rise
// R11: codes are straight binary, all ones full
// R12: holding registers change only on load
module dsl_device (
  input wire logic clk,
  input wire logic sys_rst,
  dsl_link_if.dev bus,
  output logic [dsl_pkg::CODE_W-1:0] channel_a_output,
  output logic [dsl_pkg::CODE_W-1:0] channel_b_output,
  output logic channel_a_full,
  output logic channel_a_zero,
  output logic channel_b_full,
  output logic channel_b_zero,
  output logic load_pulse,
  output logic [dsl_pkg::BITCNT_W-1:0] frame_bits,
  output logic frame_exact
);
  // link side: shift register and a free-running shift count;
  // both live on the link clock and are read here only while
  // the select line is high and the link clock is blocked
  // the whole frame, A code in the upper half after a full frame
  logic [dsl_pkg::FRAME_W-1:0] shift;
  // counts enabled link clock rises, wraps after 256 bits
  logic [dsl_pkg::BITCNT_W-1:0] shift_count;

  // system side: synchronised select level and its delayed copy
  // select level after the two-flop synchroniser
  logic select_load_s;
  // one cycle older copy, for the rising edge
  logic select_load_q;
  // high for one system cycle after each rising select;
  // it drives every copy into the holding registers
  logic load_event;

  // holding registers, one per channel, index 0 is channel A
  logic [dsl_pkg::CODE_W-1:0] hold [dsl_pkg::CHAN_N];
  // held code is all ones, one bit per channel
  logic [dsl_pkg::CHAN_N-1:0] at_full;
  // held code is all zeros, one bit per channel
  logic [dsl_pkg::CHAN_N-1:0] at_zero;

  // count snapshot from the previous load, for frame length
  logic [dsl_pkg::BITCNT_W-1:0] count_prev;
  // bits shifted since that snapshot, taken at the next load
  logic [dsl_pkg::BITCNT_W-1:0] next_frame_bits;

  // the link clock stands still outside frames, so its flops take
  // the reset without waiting for an edge; they only ever take a
  // constant there
  // shift register: one bit per rising edge while selected
  // a rise while the select line is high is ignored, which is how
  // the clock is blocked; a host that leaves the clock high when
  // it selects makes no rise here, so adds no stray shift; R06 still forbids it
  always_ff @(posedge bus.sclk or posedge sys_rst) begin
    if (sys_rst) begin
      // frame empty after reset
      shift <= dsl_pkg::FRAME_RST;
    end else if (!bus.select_load_n) begin // see R05
      // newest bit enters at the bottom, first bit works upward
      shift <= {shift[dsl_pkg::FRAME_W-2:0], bus.din}; // see R01
    end
  end

  // shift count: cleared only by sys_rst, the system side takes differences
  // so it needs no reset from the slow clock side between frames
  always_ff @(posedge bus.sclk or posedge sys_rst) begin
    if (sys_rst) begin
      // count starts from zero, as does the snapshot
      shift_count <= dsl_pkg::BITCNT_RST;
    end else if (!bus.select_load_n) begin // see R05
      // one more bit taken in this frame
      shift_count <= shift_count + 1'b1;
    end
  end

  // cascade output straight from the top stage flop; it moves only
  // on an enabled rise, so the next device in a chain samples a
  // bit that has just left this one
  assign bus.dout = shift[dsl_pkg::FRAME_W-1]; // see R07 see R08 see R09

  // select level brought into the system clock domain; it idles
  // high under reset so that no load is seen when reset ends;
  // two flops, so a select edge close to a system clock edge
  // cannot hand a half-settled level to the edge detector
  dsl_sync #(
    .RST_VAL (1'b1)
  ) u_select_sync (
    .clk (clk),
    .sys_rst (sys_rst),
    .async_in (bus.select_load_n),
    .sync_out (select_load_s)
  );

  // delayed copy for edge detection; idles high like the pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // same level as the synchroniser, so no false edge
      select_load_q <= 1'b1;
    end else begin
      // follow the synchronised level one cycle late
      select_load_q <= select_load_s;
    end
  end

  // rising select seen after synchronisation; by then the link
  // clock has been blocked for two system cycles, so the shift
  // register below is steady when it is copied
  assign load_event = select_load_s && !select_load_q; // see R04 see R10

  // holding registers and end-code flags, one set per channel;
  // the shift register is frozen while select is high, so it is
  // stable when sampled here
  genvar ch;
  generate
    for (ch = 0; ch < dsl_pkg::CHAN_N; ch++) begin : g_chan
      // channel 0 takes the upper half: its code was sent first
      localparam int TOP = dsl_pkg::FRAME_W - 1 - ch * dsl_pkg::CODE_W;

      // copy on load only, hold through the next frame
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          // zero scale until the first load
          hold[ch] <= dsl_pkg::CODE_RST;
        end else if (load_event) begin // see R12
          // this channel's half of the frozen frame
          hold[ch] <= shift[TOP -: dsl_pkg::CODE_W]; // see R02 see R03
        end
      end

      // full-scale flag, refreshed with the code
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          // reset code is zero, so not full
          at_full[ch] <= 1'b0;
        end else if (load_event) begin
          // all ones is full scale
          at_full[ch] <=
            (shift[TOP -: dsl_pkg::CODE_W] == dsl_pkg::CODE_FULL); // see R11
        end
      end

      // zero-scale flag, refreshed with the code
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          // reset code is zero, so at zero scale
          at_zero[ch] <= 1'b1;
        end else if (load_event) begin
          // all zeros is zero scale
          at_zero[ch] <=
            (shift[TOP -: dsl_pkg::CODE_W] == dsl_pkg::CODE_ZERO); // see R11
        end
      end
    end
  endgenerate

  // both channels come from the same load, so they change together
  // and a half-updated pair is never seen at the outputs
  assign channel_a_output = hold[0]; // see R04
  assign channel_b_output = hold[1]; // see R04
  // end-code flags, straight from their flops
  assign channel_a_full = at_full[0];
  assign channel_a_zero = at_zero[0];
  assign channel_b_full = at_full[1];
  assign channel_b_zero = at_zero[1];

  // one-cycle marker of each load, set at the same clock edge as the codes
  // change, so a user that sees it finds the new codes in place
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // no load during reset
      load_pulse <= 1'b0;
    end else begin
      // high only in the cycle after the edge was found
      load_pulse <= load_event;
    end
  end

  // bits shifted since the previous load, modulo the count width;
  // the count is frozen while select is high, so the difference is
  // steady when the load edge takes it
  always_comb begin
    next_frame_bits = shift_count - count_prev;
  end

  // frame length report and the snapshot it is measured from
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // nothing shifted yet
      count_prev <= dsl_pkg::BITCNT_RST;
      frame_bits <= dsl_pkg::BITCNT_RST;
      frame_exact <= 1'b0;
    end else if (load_event) begin
      // next frame is measured from this load
      count_prev <= shift_count;
      frame_bits <= next_frame_bits;
      // longer frames are normal in a cascade; this only flags it;
      // a frame of a multiple of 256 bits reads as empty
      frame_exact <= (next_frame_bits == dsl_pkg::FRAME_BITS); // see R02
    end
  end
endmodule

// file: testbench/dsl_props.sv
// wire checks on the link between the host end and the device end
module dsl_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic din,
  input wire logic select_load_n,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] rises;   // sclk rises since select fell
  logic [23:0] shadow; // din bits as the device chain should hold them
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // count rises inside one select period
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rises <= 5'h00;
    end else if ($fell(select_load_n)) begin
      rises <= 5'h00;
    end else if ($rose(sclk)) begin
      rises <= rises + 5'h01;
    end
  end
  // mirror of the shift chain, fed on every rise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shadow <= 24'h000000;
    end else if ($rose(sclk)) begin
      shadow <= {shadow[22:0], din};
    end
  end
  a_clk_idle_low: assert property (select_load_n |-> !sclk)
    else $error("link clock runs while deselected");
  a_low_before_select: assert property (
    $fell(select_load_n) |-> !sclk && !$past(sclk))
    else $error("clock high when select fell");
  a_din_setup_held: assert property ($rose(sclk) |-> $stable(din))
    else $error("data moved at clock rise");
  a_clk_high_time: assert property ($rose(sclk) |-> sclk [*2])
    else $error("clock high time short");
  a_frame_bit_count: assert property (
    $rose(select_load_n) |-> rises == 5'h18)
    else $error("frame not 24 rises");
  a_load_pulse_width: assert property (
    $rose(select_load_n) |=> select_load_n [*4])
    else $error("load high time short");
  a_dout_on_rise: assert property ($changed(dout) |-> $rose(sclk))
    else $error("serial output moved off a rise");
  a_dout_last_stage: assert property (
    $rose(sclk) |-> dout == shadow[22])
    else $error("serial output not last stage");
  c_load: cover property ($rose(select_load_n));
  c_select: cover property ($fell(select_load_n));
  c_dout_high: cover property ($rose(sclk) && dout);
endmodule

// file: testbench/test_dual_dac_serial_load.sv
// host end and device end face each other; a second device is driven here
module test_dual_dac_serial_load;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, sys_rst, send_valid, send_ready, frame_done;
  logic [11:0] code_a, code_b;
  logic [23:0] chain_data;
  logic [11:0] cha[2], chb[2]; // held codes of both devices
  logic af[2], az[2], bf[2], bz[2], lp[2], fx[2];
  logic [7:0] fb[2];
  logic [23:0] last; // codes of the previous host frame
  logic [35:0] w;    // 36 bits for the second device
  int errors, comparisons;
  dsl_link_if link ();
  dsl_link_if link2 ();
  dsl_host dsl_host_inst (.clk(clk), .sys_rst(sys_rst), .bus(link),
    .send_valid(send_valid), .send_ready(send_ready), .code_a(code_a),
    .code_b(code_b), .frame_done(frame_done), .chain_data(chain_data));
  dsl_device dsl_device_inst (.clk(clk), .sys_rst(sys_rst), .bus(link),
    .channel_a_output(cha[0]), .channel_b_output(chb[0]),
    .channel_a_full(af[0]), .channel_a_zero(az[0]),
    .channel_b_full(bf[0]), .channel_b_zero(bz[0]), .load_pulse(lp[0]),
    .frame_bits(fb[0]), .frame_exact(fx[0]));
  dsl_device dsl_device_inst_b (.clk(clk), .sys_rst(sys_rst), .bus(link2),
    .channel_a_output(cha[1]), .channel_b_output(chb[1]),
    .channel_a_full(af[1]), .channel_a_zero(az[1]),
    .channel_b_full(bf[1]), .channel_b_zero(bz[1]), .load_pulse(lp[1]),
    .frame_bits(fb[1]), .frame_exact(fx[1]));
  dsl_props dsl_props_inst (.clk(clk), .sys_rst(sys_rst), .sclk(link.sclk),
    .din(link.din), .select_load_n(link.select_load_n), .dout(link.dout));
  // system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // verdict and end of run
  task automatic results();
    if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // a wait that ran out
  task automatic timeout();
    errors++;
    $display("[FAIL] %0t wait ran out", $time);
    results();
  endtask
  // one compare of any result, widened to 24 bits
  task automatic check(input logic [23:0] got, input logic [23:0] exp,
                       input string m);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one host frame, checked mid-frame and after the load
  task automatic send(input logic [11:0] a, input logic [11:0] b);
    int n;
    int pulses;
    logic [3:0] f;
    n = 0;
    pulses = 0;
    f = {a == dsl_pkg::CODE_FULL, a == dsl_pkg::CODE_ZERO,
         b == dsl_pkg::CODE_FULL, b == dsl_pkg::CODE_ZERO};
    while (send_ready !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 200) timeout();
    end
    @(posedge clk);
    send_valid <= 1'b1;
    code_a <= a;
    code_b <= b;
    @(posedge clk);
    send_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (lp[0] === 1'b1) pulses++;
      if (n == 50) check({cha[0], chb[0]}, last, "held mid-frame");
      if (n > 300) timeout();
    end while (frame_done !== 1'b1);
    check(24'(n), 24'h000069, "frame latency");
    check(24'(pulses), 24'h000001, "load count");
    check({cha[0], chb[0]}, {a, b}, "held codes");
    check(24'({af[0], az[0], bf[0], bz[0]}), 24'(f), "scale flags");
    check(24'(fb[0]), 24'(dsl_pkg::FRAME_BITS), "bit count");
    check(24'(fx[0]), 24'h000001, "exact frame");
    check(chain_data, last, "returned bits");
    last = {a, b};
  endtask
  // one bit into the second device at the 30 ns link rate
  task automatic lbit(input logic b);
    link2.din = b;
    #15 link2.sclk = 1'b1;
    #15 link2.sclk = 1'b0;
  endtask
  // main sequence
  initial begin
    // applied as an update, after every process waits on its edge,
    // so the link-clock flops with their own reset see it rise
    sys_rst <= 1'b1;
    send_valid = 1'b0;
    code_a = 12'h000;
    code_b = 12'h000;
    link2.sclk = 1'b0;
    link2.din = 1'b0;
    link2.select_load_n = 1'b1;
    errors = 0;
    comparisons = 0;
    last = 24'h000000;
    w = 36'hC3A5A17E9;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // end codes and mixed codes, back to back
    send(12'hFFF, 12'h000);
    send(12'h000, 12'hFFF);
    send(12'hA5C, 12'h3E1);
    send(12'h801, 12'h7FE);
    // 36 bits: the first 12 come out again on the serial output
    link2.select_load_n = 1'b0;
    #20;
    for (int i = 35; i >= 0; i--) begin
      lbit(w[i]);
      if (i <= 12) check(24'(link2.dout), 24'(w[i + 23]), "chain out");
    end
    #30 link2.select_load_n = 1'b1;
    repeat (8) @(posedge clk);
    check({cha[1], chb[1]}, w[23:0], "last 24 held");
    check(24'(fb[1]), 24'h000024, "long count");
    check(24'(fx[1]), 24'h000000, "inexact frame");
    // clocks while deselected must not shift
    repeat (4) lbit(1'b1);
    check(24'(link2.dout), 24'(w[23]), "blocked out");
    link2.select_load_n = 1'b0;
    #60 link2.select_load_n = 1'b1;
    repeat (8) @(posedge clk);
    check({cha[1], chb[1]}, w[23:0], "blocked shift");
    results();
  end
endmodule
